// ==== verification/test_task_file_control_registers.sv ====
// Testbench for the task file control register block
`timescale 1ns/1ps
module test_task_file_control_registers
  import tfc_pkg::*;
();
  typedef struct packed {logic w; logic [4:0] a; logic [7:0] d; logic [7:0] e;} tfc_row_t;
  localparam logic [7:0] ABORTED = TFC_DIAG_CODE_DEF | (8'h01 << TFC_ERR_ABORTED_POS);
  tfc_row_t rows [6] = '{'{1'h0, TFC_ADDR_ERROR_FEATURE, 8'h00, TFC_DIAG_CODE_DEF},
    '{1'h1, TFC_ADDR_DRIVE_HEAD, 8'h0F, 8'h0F}, '{1'h1, TFC_ADDR_SECTOR_COUNT, 8'h3C, 8'h3C},
    '{1'h1, TFC_ADDR_SECTOR_NUMBER, 8'h5A, 8'h5A}, '{1'h1, TFC_ADDR_ERROR_FEATURE, 8'hA5, TFC_DIAG_CODE_DEF},
    '{1'h1, TFC_ADDR_DEVICE_CONTROL, 8'h00, 8'h50}};
  logic        clk = 1'h0, rst_b = 1'h0, busy = 1'h0, intp = 1'h0, slp = 1'h0;
  logic [2:0]  evs = 3'h0;
  logic        rd_n, wr_n, dma_n, oe_n, iro, iroe, soft_reset_bit, sel, cs;
  logic [7:0]  din, dout, q;
  tfc_addr_t   ba;
  tfc_params_t prm;
  int          mismatches = 0, checks = 0, strobes = 0, cyc = 0;
  tfc_task_file DUT (.ref_clk(clk), .rst_b(rst_b), .command_block_select_n(ba.command_block_select_n),
    .control_block_select_n(ba.control_block_select_n), .register_address_line_2(ba.addr[2]),
    .register_address_line_1(ba.addr[1]), .register_address_line_0(ba.addr[0]), .dior_n(rd_n),
    .diow_n(wr_n), .dma_acknowledge_n(dma_n), .dd_in(din), .dd_out(dout), .dd_oe_n(oe_n),
    .status_byte(8'h50), .busy_flag(busy), .data_request_flag(1'h0), .error_flag(1'h0),
    .sleep_mode(slp), .interrupt_pending(intp), .signature_load(evs[0]), .diag_done(evs[1]),
    .command_reject(evs[2]), .interrupt_request_output(iro), .interrupt_request_oe_n(iroe),
    .soft_reset_active(soft_reset_bit), .device_selected(sel), .command_strobe(cs), .command_params(prm));
  tfc_host_model host (.ref_clk(clk), .bus_addr(ba), .dior_n(rd_n), .diow_n(wr_n),
    .dma_acknowledge_n(dma_n), .dd_in(din), .dd_out(dout), .dd_oe_n(oe_n));
  // ==========================================================================
  // Clock, cycle ceiling, strobe count
  // ==========================================================================
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cs === 1'h1) strobes++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // ==========================================================================
  // Compare and helper tasks
  // ==========================================================================
  task automatic ck(input logic [39:0] g, input logic [39:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cb(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    host.rd(a, q);
    ck(q, e);
  endtask
  task automatic ev(input int k);
    @(posedge clk);
    evs[k] <= 1'h1;
    @(posedge clk);
    evs[k] <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    cb(oe_n, 1'h1);
    ck(prm, 40'h0);
    foreach (rows[i]) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d, 1'h1);
      rc(rows[i].a, rows[i].e);
    end
    $display("register table done");
    host.wr(TFC_ADDR_COMMAND, TFC_CMD_DIAGNOSTIC, 1'h1);
    ck(prm, {8'hA5, 8'h3C, 8'h5A, 8'h0F, TFC_CMD_DIAGNOSTIC});
    ck(strobes, 40'h1);
    busy <= 1'h1;
    host.wr(TFC_ADDR_SECTOR_COUNT, 8'h77, 1'h1);
    host.wr(TFC_ADDR_COMMAND, TFC_CMD_DIAGNOSTIC, 1'h1);
    ck(strobes, 40'h1);
    host.wr(TFC_ADDR_COMMAND, TFC_CMD_DEVICE_RESET, 1'h1);
    ck(prm, {8'hA5, 8'h3C, 8'h5A, 8'h0F, TFC_CMD_DEVICE_RESET});
    busy <= 1'h0;
    host.wr(TFC_ADDR_SECTOR_NUMBER, 8'hC3, 1'h0);
    rc(TFC_ADDR_SECTOR_NUMBER, 8'h5A);
    $display("command latch done");
    intp <= 1'h1;
    host.wr(TFC_ADDR_DEVICE_CONTROL, 8'h02, 1'h1);
    cb(iroe, 1'h1);
    host.wr(TFC_ADDR_DEVICE_CONTROL, 8'h00, 1'h1);
    cb(iroe, 1'h0);
    cb(iro, 1'h1);
    host.wr(TFC_ADDR_DRIVE_HEAD, 8'hBF, 1'h1);
    cb(sel, 1'h0);
    cb(iroe, 1'h1);
    host.wr(TFC_ADDR_COMMAND, TFC_CMD_DIAGNOSTIC, 1'h1);
    ck(strobes, 40'h2);
    slp <= 1'h1;
    host.wr(TFC_ADDR_DEVICE_CONTROL, 8'h04, 1'h1);
    cb(soft_reset_bit, 1'h1);
    host.wr(TFC_ADDR_DEVICE_CONTROL, 8'h00, 1'h1);
    cb(soft_reset_bit, 1'h0);
    slp <= 1'h0;
    rc(TFC_ADDR_SECTOR_COUNT, 8'h00);
    rc(TFC_ADDR_ERROR_FEATURE, TFC_DIAG_CODE_DEF);
    host.wr(TFC_ADDR_DRIVE_HEAD, 8'h10, 1'h1);
    ev(0);
    cb(sel, 1'h1);
    ev(2);
    rc(TFC_ADDR_ERROR_FEATURE, ABORTED);
    ev(1);
    rc(TFC_ADDR_ERROR_FEATURE, TFC_DIAG_CODE_DEF);
    $display("control and error done");
    test_done();
  end
endmodule

// ==== verification/tfc_host_model.sv ====
// Host adapter model driving single byte cycles on the parallel bus
`timescale 1ns/1ps
module tfc_host_model
  import tfc_pkg::*;
(
  input  wire logic       ref_clk,
  output tfc_addr_t       bus_addr,
  output logic            dior_n,
  output logic            diow_n,
  output logic            dma_acknowledge_n,
  output logic      [7:0] dd_in,
  input  wire logic [7:0] dd_out,
  input  wire logic       dd_oe_n
);
  initial begin
    bus_addr = 5'h1F;
    dior_n = 1'h1;
    diow_n = 1'h1;
    dma_acknowledge_n = 1'h1;
    dd_in = 8'h00;
  end
  // Strobe 5 cycles low; bus held 5 cycles after release to cover the sync lag
  task automatic xfer(input logic [4:0] a, input logic [7:0] d, input logic dma_n, input logic w,
                      output logic [7:0] q);
    @(posedge ref_clk);
    bus_addr <= {a[3], a[4], a[2:0]};
    dd_in <= d;
    dma_acknowledge_n <= dma_n;
    @(posedge ref_clk);
    if (w) diow_n <= 1'h0;
    else dior_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    q = dd_oe_n ? 8'hXX : dd_out;
    @(posedge ref_clk);
    diow_n <= 1'h1;
    dior_n <= 1'h1;
    repeat (5) @(posedge ref_clk);
    bus_addr <= {1'h1, 1'h1, ~a[2:0]};
    dd_in <= ~d;
    dma_acknowledge_n <= 1'h1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic dma_n);
    logic [7:0] q;
    xfer(a, (a == TFC_ADDR_DEVICE_CONTROL) ? (d & 8'h06) : d, dma_n, 1'h1, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] q);
    xfer(a, 8'h00, 1'h1, 1'h0, q);
  endtask
endmodule

// ==== verification/tfc_task_file_assertions.sv ====
// Checker for the task file control register block, bound to its ports
`timescale 1ns/1ps
module tfc_task_file_chk
  import tfc_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       command_block_select_n,
  input wire logic       control_block_select_n,
  input wire logic       register_address_line_2,
  input wire logic       register_address_line_1,
  input wire logic       register_address_line_0,
  input wire logic       dior_n,
  input wire logic       diow_n,
  input wire logic       dma_acknowledge_n,
  input wire logic [7:0] dd_in,
  input wire logic       dd_oe_n,
  input wire logic       busy_flag,
  input wire logic       sleep_mode,
  input wire logic       interrupt_request_oe_n,
  input wire logic       soft_reset_active,
  input wire logic       device_selected,
  input wire logic       command_strobe
);
  // ==========================================================================
  // Write release sequences
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [2:0] da;
  assign da = {register_address_line_2, register_address_line_1, register_address_line_0};
  sequence ctl_wr;
    $rose(diow_n) && !control_block_select_n && command_block_select_n && da == 3'h6 && dma_acknowledge_n;
  endsequence
  sequence cmd_wr;
    $rose(diow_n) && !command_block_select_n && control_block_select_n && da == 3'h7;
  endsequence
  // ==========================================================================
  // Properties
  // ==========================================================================
  a_soft_reset_bit_applies: assert property (ctl_wr ##0 dd_in[2] |-> ##[1:5] soft_reset_active)
    else $error("soft reset bit not applied");
  a_int_enabled: assert property (ctl_wr ##0 (dd_in[2:1] == 2'h0 && device_selected)
    |-> ##[1:5] !interrupt_request_oe_n)
    else $error("interrupt not driven");
  a_int_disabled: assert property (ctl_wr ##0 dd_in[1] |-> ##[1:5] interrupt_request_oe_n)
    else $error("interrupt driven while disabled");
  a_int_needs_select: assert property (!interrupt_request_oe_n |-> device_selected)
    else $error("interrupt driven while not selected");
  a_cmd_accepted: assert property (cmd_wr ##0 (dma_acknowledge_n && !busy_flag && !sleep_mode
    && device_selected && !soft_reset_active) |-> ##[1:6] command_strobe)
    else $error("command write not accepted");
  a_busy_blocks_cmd: assert property (cmd_wr ##0 (busy_flag && dd_in != TFC_CMD_DEVICE_RESET)
    |-> ##1 !command_strobe [*6])
    else $error("command accepted while busy");
  a_strobe_single: assert property (command_strobe |=> !command_strobe)
    else $error("command strobe longer than one cycle");
  a_read_drive: assert property (!dd_oe_n |-> !$past(dior_n, 3))
    else $error("data bus driven without read strobe");
endmodule
bind tfc_task_file tfc_task_file_chk u_chk (.*);

// ==== verilog/tfc_pkg.sv ====
// Package for the task file control register block: addresses, fields, carriers
package tfc_pkg;

  // ==========================================================================
  // Register addresses {cs1_n, cs0_n, da2, da1, da0}, selects active low
  // ==========================================================================
  localparam logic [4:0] TFC_ADDR_DEVICE_CONTROL = 5'h0E;  // control block, 110
  localparam logic [4:0] TFC_ADDR_DRIVE_HEAD     = 5'h16;  // command block, 110
  localparam logic [4:0] TFC_ADDR_ERROR_FEATURE  = 5'h11;  // command block, 001
  localparam logic [4:0] TFC_ADDR_SECTOR_COUNT   = 5'h12;  // command block, 010
  localparam logic [4:0] TFC_ADDR_SECTOR_NUMBER  = 5'h13;  // command block, 011
  localparam logic [4:0] TFC_ADDR_COMMAND        = 5'h17;  // command block, 111

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int TFC_CTL_SOFT_RESET_POS   = 2;
  localparam int TFC_CTL_INT_DISABLE_POS  = 1;
  localparam int TFC_DH_SELECT_POS        = 4;
  localparam int TFC_ERR_ABORTED_POS      = 2;
  localparam logic [7:0] TFC_DH_OBSOLETE_MASK = 8'hA0;

  // ==========================================================================
  // Reset values and command codes
  // ==========================================================================
  localparam logic [7:0] TFC_BYTE_ZERO        = 8'h00;
  localparam logic [7:0] TFC_DIAG_CODE_DEF    = 8'h01;
  localparam logic [7:0] TFC_CMD_DEVICE_RESET = 8'h08;
  localparam logic [7:0] TFC_CMD_DIAGNOSTIC   = 8'h90;

  // Command parameters latched at a command code write
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] number;
    logic [7:0] drive_head;
    logic [7:0] code;
  } tfc_params_t;

  // Parallel bus access, sampled and synchronised
  typedef struct packed {
    logic       command_block_select_n;
    logic       control_block_select_n;
    logic [2:0] addr;
  } tfc_addr_t;

endpackage

// ==== verilog/tfc_task_file.sv ====
// Task file control registers: control, drive select, error/feature, sector registers
`timescale 1ns/1ps

// How it works
// - Control address is write only; reads there return alternate status.
// - Control write acts at once and is taken whichever device is selected.
// - Soft reset bit runs the software reset, even in sleep.
// - Interrupt driven only when disable bit clear and device selected, else released.
// - Drive select valid when not busy; packet devices keep it in sleep.
// - Select bit acts at once; other bits become parameters at command write.
// - Select bit zero picks device 0, one picks device 1; respond when selected.
// - Obsolete drive select bits 7 and 5 are ignored.
// - Error and feature share an address: read error, write feature.
// - Error contents held stable while idle with the error flag set.
// - Resets and diagnostic or device reset completion load a diagnostic code.
// - Rejected commands set the aborted flag, bit 2 of error.
// - Feature written only when idle; latched as parameter at command write.
// - Sector registers written only when idle; reads valid when idle.
// - Sector registers latched as command parameters at command write.
// - While busy, command-block writes are ignored except device reset.
module tfc_task_file
  import tfc_pkg::*;
#(
  parameter logic [7:0] DIAG_CODE     = TFC_DIAG_CODE_DEF,
  parameter bit         DEVICE_NUMBER = 1'b0,
  parameter bit         PACKET_DEVICE = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        command_block_select_n,
  input  wire logic        control_block_select_n,
  input  wire logic        register_address_line_2,
  input  wire logic        register_address_line_1,
  input  wire logic        register_address_line_0,
  input  wire logic        dior_n,
  input  wire logic        diow_n,
  input  wire logic        dma_acknowledge_n,
  input  wire logic [7:0]  dd_in,
  output logic      [7:0]  dd_out,
  output logic             dd_oe_n,
  input  wire logic [7:0]  status_byte,
  input  wire logic        busy_flag,
  input  wire logic        data_request_flag,
  input  wire logic        error_flag,
  input  wire logic        sleep_mode,
  input  wire logic        interrupt_pending,
  input  wire logic        signature_load,
  input  wire logic        diag_done,
  input  wire logic        command_reject,
  output logic             interrupt_request_output,
  output logic             interrupt_request_oe_n,
  output logic             soft_reset_active,
  output logic             device_selected,
  output logic             command_strobe,
  output tfc_params_t      command_params
);

  // ==========================================================================
  // Pin synchronisers, two stages before any logic
  // ==========================================================================
  tfc_addr_t  addr_s1_q;
  tfc_addr_t  addr_s2_q;
  logic [1:0] strobe_s1_q;
  logic [1:0] strobe_s2_q;
  logic [1:0] strobe_s3_q;
  logic       dma_acknowledge_n_n_s1_q;
  logic       dma_acknowledge_n_n_s2_q;
  logic [7:0] data_s1_q;
  logic [7:0] data_s2_q;

  // Only the second stage feeds logic; the first may still be settling
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_s1_q <= '1;
      addr_s2_q <= '1;
    end else begin
      addr_s1_q <= '{command_block_select_n, control_block_select_n,
                     {register_address_line_2, register_address_line_1, register_address_line_0}};
      addr_s2_q <= addr_s1_q;
    end
  end

  // Third strobe stage feeds only the edge detector; idle high so reset makes no false edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_s1_q <= '1;
      strobe_s2_q <= '1;
      strobe_s3_q <= '1;
    end else begin
      strobe_s1_q <= {dior_n, diow_n};
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_acknowledge_n_n_s1_q <= 1'b1;
      dma_acknowledge_n_n_s2_q <= 1'b1;
    end else begin
      dma_acknowledge_n_n_s1_q <= dma_acknowledge_n;
      dma_acknowledge_n_n_s2_q <= dma_acknowledge_n_n_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_s1_q <= TFC_BYTE_ZERO;
      data_s2_q <= TFC_BYTE_ZERO;
    end else begin
      data_s1_q <= dd_in;
      data_s2_q <= data_s1_q;
    end
  end

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic hit(input tfc_addr_t a, input logic [4:0] target);
    hit = ({a.control_block_select_n, a.command_block_select_n, a.addr} == target);
  endfunction

  logic [4:0] addr_code;
  logic       write_done;
  logic       read_active;
  logic       dev_match;
  logic       cmd_block_ok;

  // Write taken at the rising edge of the synchronised write strobe
  assign write_done = strobe_s2_q[0] && !strobe_s3_q[0];
  assign read_active = !strobe_s2_q[1];
  // Same bit order as the package codes: control select, command select, address
  assign addr_code = {addr_s2_q.control_block_select_n, addr_s2_q.command_block_select_n, addr_s2_q.addr};

  logic [7:0] control_q;
  logic [7:0] drive_head_q;
  logic [7:0] error_q;
  logic [7:0] feature_q;
  logic [7:0] count_q;
  logic [7:0] number_q;

  assign dev_match = (drive_head_q[TFC_DH_SELECT_POS] == DEVICE_NUMBER);
  // Ignoring writes while busy protects the device's own parameters
  assign cmd_block_ok = write_done && dma_acknowledge_n_n_s2_q && dev_match && !busy_flag;

  logic wr_ctl;
  logic wr_dh;
  logic wr_feat;
  logic wr_cnt;
  logic wr_num;
  logic wr_cmd;

  always_comb begin
    wr_ctl  = 1'b0;
    wr_dh   = 1'b0;
    wr_feat = 1'b0;
    wr_cnt  = 1'b0;
    wr_num  = 1'b0;
    wr_cmd  = 1'b0;
    if (hit(addr_s2_q, TFC_ADDR_DEVICE_CONTROL)) begin
      wr_ctl = write_done;
    end else if (hit(addr_s2_q, TFC_ADDR_DRIVE_HEAD)) begin
      // Both devices track the select bit, so no device match here
      wr_dh = write_done && dma_acknowledge_n_n_s2_q && !busy_flag;
    end else if (hit(addr_s2_q, TFC_ADDR_ERROR_FEATURE)) begin
      wr_feat = cmd_block_ok;
    end else if (hit(addr_s2_q, TFC_ADDR_SECTOR_COUNT)) begin
      wr_cnt = cmd_block_ok;
    end else if (hit(addr_s2_q, TFC_ADDR_SECTOR_NUMBER)) begin
      wr_num = cmd_block_ok;
    end else if (hit(addr_s2_q, TFC_ADDR_COMMAND)) begin
      wr_cmd = write_done && dma_acknowledge_n_n_s2_q && dev_match &&
               (!busy_flag || data_s2_q == TFC_CMD_DEVICE_RESET) &&
               (!sleep_mode || (PACKET_DEVICE && data_s2_q == TFC_CMD_DEVICE_RESET));
    end
  end

  // ==========================================================================
  // Device control, write only, both devices
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_q <= TFC_BYTE_ZERO;
    end else if (wr_ctl) begin
      control_q <= data_s2_q;
    end
  end

  // Sleep does not gate this: soft reset must wake the device
  assign soft_reset_active = control_q[TFC_CTL_SOFT_RESET_POS];

  // Interrupt level from a flop, so the pin never carries a glitch of the device's gates
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_request_output <= 1'b0;
    end else begin
      interrupt_request_output <= interrupt_pending;
    end
  end

  // Interrupt output: enabled only when selected with the disable bit clear
  assign interrupt_request_oe_n = control_q[TFC_CTL_INT_DISABLE_POS] || !dev_match;
  assign device_selected = dev_match;

  // ==========================================================================
  // Drive select; obsolete bits dropped
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_head_q <= TFC_BYTE_ZERO;
    end else if (soft_reset_active || signature_load) begin
      drive_head_q <= TFC_BYTE_ZERO;
    end else if (sleep_mode && !PACKET_DEVICE) begin
      drive_head_q <= TFC_BYTE_ZERO;
    end else if (wr_dh) begin
      drive_head_q <= data_s2_q & ~TFC_DH_OBSOLETE_MASK;
    end
  end

  // ==========================================================================
  // Error register
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      error_q <= DIAG_CODE;
    end else if (soft_reset_active || diag_done) begin
      error_q <= DIAG_CODE;
    end else if (command_reject) begin
      error_q <= error_q | (8'h01 << TFC_ERR_ABORTED_POS);
    end else if (wr_cmd) begin
      error_q <= TFC_BYTE_ZERO;
    end
    // Otherwise held, so contents stay stable while error flag is set
  end

  // ==========================================================================
  // Feature and sector registers
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      feature_q <= TFC_BYTE_ZERO;
    end else if (soft_reset_active) begin
      feature_q <= TFC_BYTE_ZERO;
    end else if (wr_feat) begin
      feature_q <= data_s2_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= TFC_BYTE_ZERO;
    end else if (soft_reset_active) begin
      count_q <= TFC_BYTE_ZERO;
    end else if (wr_cnt) begin
      count_q <= data_s2_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      number_q <= TFC_BYTE_ZERO;
    end else if (soft_reset_active) begin
      number_q <= TFC_BYTE_ZERO;
    end else if (wr_num) begin
      number_q <= data_s2_q;
    end
  end

  // ==========================================================================
  // Parameter latch at command code write
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      command_strobe <= 1'b0;
    end else begin
      command_strobe <= wr_cmd;
    end
  end

  // Parameters copy the registers as they stand at the command write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      command_params <= '0;
    end else if (wr_cmd) begin
      command_params <= '{feature: feature_q, count: count_q, number: number_q,
                          drive_head: drive_head_q, code: data_s2_q};
    end
  end

  // ==========================================================================
  // Read data path
  // ==========================================================================
  logic [7:0] rd_d;
  logic       rd_hit;

  always_comb begin
    rd_d   = TFC_BYTE_ZERO;
    rd_hit = 1'b1;
    if (addr_code == TFC_ADDR_DEVICE_CONTROL) begin
      rd_d = status_byte;
    end else if (addr_code == TFC_ADDR_DRIVE_HEAD) begin
      rd_d = drive_head_q;
    end else if (addr_code == TFC_ADDR_ERROR_FEATURE) begin
      rd_d = error_q;
    end else if (addr_code == TFC_ADDR_SECTOR_COUNT) begin
      rd_d = count_q;
    end else if (addr_code == TFC_ADDR_SECTOR_NUMBER) begin
      rd_d = number_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dd_out  <= TFC_BYTE_ZERO;
      dd_oe_n <= 1'b1;
    end else begin
      dd_out  <= rd_d;
      // Only the selected device answers reads
      dd_oe_n <= !(read_active && rd_hit && dev_match && dma_acknowledge_n_n_s2_q);
    end
  end

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // Every field must land inside the byte that carries it
  if (TFC_CTL_SOFT_RESET_POS >= $bits(TFC_BYTE_ZERO) || TFC_CTL_INT_DISABLE_POS >= $bits(TFC_BYTE_ZERO) ||
      TFC_DH_SELECT_POS >= $bits(TFC_BYTE_ZERO) || TFC_ERR_ABORTED_POS >= $bits(TFC_BYTE_ZERO)) begin : g_bad_field
    $error("register field position outside its byte");
  end
  // The select bit must survive the obsolete-bit mask, or device 1 would never match
  if (TFC_DH_OBSOLETE_MASK[TFC_DH_SELECT_POS]) begin : g_bad_mask
    $error("drive select bit falls under the obsolete mask");
  end
  // A zero diagnostic code could not be told from the clear left by a command write
  if (DIAG_CODE == TFC_BYTE_ZERO) begin : g_bad_diag
    $error("diagnostic code must not be zero");
  end

endmodule
